// >>> rcb_consts.svh
// Register indices, field positions and counts for the reset-cause block
`ifndef RCB_CONSTS_SVH
`define RCB_CONSTS_SVH

`define RCB_ADDR_W 10
`define RCB_IDX_PORT2 8'hA0
`define RCB_IDX_AUX 8'hA2
`define RCB_IDX_BOD 8'hA3
`define RCB_WORD_LSB 2'h0

`define RCB_PORT_PIN 0
`define RCB_AUX_SOFT 7
`define RCB_AUX_PIN 6
`define RCB_AUX_PCOV 5
`define RCB_AUX_GF 3

`define RCB_BOD_EN 7
`define RCB_BOD_THR_HI 5
`define RCB_BOD_THR_LO 4
`define RCB_BOD_EVT 3
`define RCB_BOD_RST 2
`define RCB_BOD_RCF 1
`define RCB_BOD_LVL 0

`define RCB_CFG_EN 7
`define RCB_CFG_THR_HI 5
`define RCB_CFG_THR_LO 4
`define RCB_CFG_RST 2

`define RCB_WARM_TICKS 2'h3
`define RCB_ZERO32 32'h0000_0000

`endif

// >>> rcb_pkg.sv
// Types shared by the reset-cause and brown-out block
package rcb_pkg;
    typedef logic [1:0] rcb_thr_t;
    typedef logic [1:0] rcb_tick_t;
    typedef enum logic [1:0] {
        BOD_OFF,
        BOD_WARM,
        BOD_ON
    } rcb_bod_e;
endpackage : rcb_pkg

// >>> rcb_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module rcb_sync3 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;
    logic out_nxt;

    always_comb begin
        out_nxt = out_r;
        if (s2_r == s3_r) begin
            out_nxt = s3_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            out_r <= 1'b0;
        end else if (ce) begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule : rcb_sync3

// >>> rcb_top.sv
// Reset-cause flags, brown-out control and single-pin port behind an APB slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "rcb_consts.svh"
module rcb_top (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`RCB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RESET_PIN_N,
    input wire logic RESET_PIN_DISABLE_CFG,
    input wire logic [7:0] CONFIG_BYTE_TWO,
    input wire logic DEBUG_MODE,
    input wire logic DEBUG_ENABLE_CFG,
    input wire logic SOFT_RESET_REQ,
    input wire logic PC_OVERFLOW,
    input wire logic LOW_SPEED_OSC,
    input wire logic SUPPLY_BELOW,
    input wire logic BROWNOUT_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    output logic CHIP_RESET,
    output logic BROWNOUT_IRQ,
    output logic BROWNOUT_DET_ON,
    output logic [1:0] BROWNOUT_THRESHOLD_SEL
);
    logic pin_s;
    logic osc_s;
    logic below_s;

    rcb_sync3 u_sync_pin (
        .clk(CLOCK),
        .rst_b(RST_B),
        .ce(CE),
        .din(RESET_PIN_N),
        .dout(pin_s)
    );

    rcb_sync3 u_sync_osc (
        .clk(CLOCK),
        .rst_b(RST_B),
        .ce(CE),
        .din(LOW_SPEED_OSC),
        .dout(osc_s)
    );

    rcb_sync3 u_sync_below (
        .clk(CLOCK),
        .rst_b(RST_B),
        .ce(CE),
        .din(SUPPLY_BELOW),
        .dout(below_s)
    );

    // APB decode
    logic [7:0] idx;
    logic word_ok;
    logic sel_port;
    logic sel_aux;
    logic sel_bod;
    logic access;
    logic wr_now;

    assign idx = PADDR[`RCB_ADDR_W-1:2];
    assign word_ok = (PADDR[1:0] == `RCB_WORD_LSB);
    assign sel_port = word_ok && (idx == `RCB_IDX_PORT2);
    assign sel_aux = word_ok && (idx == `RCB_IDX_AUX);
    assign sel_bod = word_ok && (idx == `RCB_IDX_BOD);
    assign access = PSEL && PENABLE;
    // Write lands at the edge where the master sees PREADY high
    assign wr_now = access && PREADY && PWRITE;

    // Register state
    logic soft_f_r, soft_f_nxt;
    logic pin_f_r, pin_f_nxt;
    logic pcov_f_r, pcov_f_nxt;
    logic gf_r, gf_nxt;
    logic en_r, en_nxt;
    rcb_pkg::rcb_thr_t thr_r, thr_nxt;
    logic evt_f_r, evt_f_nxt;
    logic rst_en_r, rst_en_nxt;
    logic bor_f_r, bor_f_nxt;
    logic load_r, load_nxt;
    logic chip_rst_r, chip_rst_nxt;
    logic irq_r, irq_nxt;

    // Brown-out warm-up state, input edge delays and detector level
    rcb_pkg::rcb_bod_e bod_st_r, bod_st_nxt;
    rcb_pkg::rcb_tick_t ticks_r, ticks_nxt;
    logic osc_d_r;
    logic pin_d_r;
    logic below_d_r;
    logic bod_valid;
    logic level;

    // APB answer
    logic [31:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt;
    logic err_r, err_nxt;

    // Events
    logic pin_fall;
    logic pin_rst;
    logic soft_rst;
    logic pcov_rst;
    logic bo_cross;
    logic bo_rst;
    logic any_rst;

    assign bod_valid = (bod_st_r == rcb_pkg::BOD_ON);
    assign level = en_r && bod_valid && below_s;
    assign pin_fall = pin_d_r && !pin_s;
    // Pin acts as reset only while not reassigned as port input
    assign pin_rst = RESET_PIN_DISABLE_CFG && pin_fall;
    assign soft_rst = SOFT_RESET_REQ;
    // Debug session without debug config: flag only, no reset
    assign pcov_rst = PC_OVERFLOW && !(DEBUG_MODE && !DEBUG_ENABLE_CFG);
    assign bo_cross = bod_valid && en_r && (below_s != below_d_r);
    assign bo_rst = bo_cross && below_s && rst_en_r;
    assign any_rst = soft_rst || pin_rst || pcov_rst || bo_rst;

    // Warm-up: counts slow-oscillator rising edges after enabling
    always_comb begin
        bod_st_nxt = bod_st_r;
        ticks_nxt = ticks_r;
        case (bod_st_r)
            rcb_pkg::BOD_OFF: begin
                ticks_nxt = '0;
                if (en_r) begin
                    bod_st_nxt = rcb_pkg::BOD_WARM;
                end
            end
            rcb_pkg::BOD_WARM: begin
                if (!en_r) begin
                    bod_st_nxt = rcb_pkg::BOD_OFF;
                end else if (osc_s && !osc_d_r) begin
                    ticks_nxt = rcb_pkg::rcb_tick_t'(ticks_r + 2'h1);
                    if (ticks_r == `RCB_WARM_TICKS - 2'h1) begin
                        bod_st_nxt = rcb_pkg::BOD_ON;
                    end
                end
            end
            rcb_pkg::BOD_ON: begin
                if (!en_r) begin
                    bod_st_nxt = rcb_pkg::BOD_OFF;
                end
            end
            default: begin
                bod_st_nxt = rcb_pkg::BOD_OFF;
            end
        endcase
    end

    // Flags: a hardware set wins over a software clear in the same cycle
    always_comb begin
        soft_f_nxt = soft_f_r;
        pin_f_nxt = pin_f_r;
        pcov_f_nxt = pcov_f_r;
        gf_nxt = gf_r;
        en_nxt = en_r;
        thr_nxt = thr_r;
        evt_f_nxt = evt_f_r;
        rst_en_nxt = rst_en_r;
        bor_f_nxt = bor_f_r;
        load_nxt = 1'b0;
        if (wr_now && sel_aux) begin
            soft_f_nxt = PWDATA[`RCB_AUX_SOFT];
            pin_f_nxt = PWDATA[`RCB_AUX_PIN];
            pcov_f_nxt = PWDATA[`RCB_AUX_PCOV];
            gf_nxt = PWDATA[`RCB_AUX_GF];
        end
        // Level bit is not stored, so writes to it are dropped
        if (wr_now && sel_bod) begin
            en_nxt = PWDATA[`RCB_BOD_EN];
            thr_nxt = {PWDATA[`RCB_BOD_THR_HI], PWDATA[`RCB_BOD_THR_LO]};
            evt_f_nxt = PWDATA[`RCB_BOD_EVT];
            rst_en_nxt = PWDATA[`RCB_BOD_RST];
            bor_f_nxt = PWDATA[`RCB_BOD_RCF];
        end
        if (soft_rst) begin
            soft_f_nxt = 1'b1;
        end
        if (pin_rst) begin
            pin_f_nxt = 1'b1;
        end
        if (PC_OVERFLOW) begin
            pcov_f_nxt = 1'b1;
        end
        if (bo_cross) begin
            evt_f_nxt = 1'b1;
        end
        if (bo_rst) begin
            bor_f_nxt = 1'b1;
        end
        // Any reset, including power-up, reloads fields from config
        if (load_r || any_rst) begin
            en_nxt = CONFIG_BYTE_TWO[`RCB_CFG_EN];
            thr_nxt = {CONFIG_BYTE_TWO[`RCB_CFG_THR_HI], CONFIG_BYTE_TWO[`RCB_CFG_THR_LO]};
            rst_en_nxt = CONFIG_BYTE_TWO[`RCB_CFG_RST];
            evt_f_nxt = bo_cross || (CONFIG_BYTE_TWO[`RCB_CFG_EN] && below_s);
        end
        chip_rst_nxt = any_rst;
        irq_nxt = evt_f_r && BROWNOUT_IRQ_ENABLE && GLOBAL_IRQ_ENABLE;
    end

    // APB answer one cycle into the access phase
    always_comb begin
        rdata_nxt = `RCB_ZERO32;
        ready_nxt = access && !ready_r;
        err_nxt = 1'b0;
        if (access && !ready_r) begin
            err_nxt = !(sel_port || sel_aux || sel_bod);
            if (sel_port) begin
                // Upper bits stay zero
                rdata_nxt[`RCB_PORT_PIN] = !RESET_PIN_DISABLE_CFG && pin_s;
            end
            if (sel_aux) begin
                // Bits 2 to 0 and 4 read zero
                rdata_nxt[`RCB_AUX_SOFT] = soft_f_r;
                rdata_nxt[`RCB_AUX_PIN] = pin_f_r;
                rdata_nxt[`RCB_AUX_PCOV] = pcov_f_r;
                rdata_nxt[`RCB_AUX_GF] = gf_r;
            end
            if (sel_bod) begin
                rdata_nxt[`RCB_BOD_EN] = en_r;
                rdata_nxt[`RCB_BOD_THR_HI] = thr_r[1];
                rdata_nxt[`RCB_BOD_THR_LO] = thr_r[0];
                rdata_nxt[`RCB_BOD_EVT] = evt_f_r;
                rdata_nxt[`RCB_BOD_RST] = rst_en_r;
                rdata_nxt[`RCB_BOD_RCF] = bor_f_r;
                rdata_nxt[`RCB_BOD_LVL] = level;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            soft_f_r <= 1'b0;
            pin_f_r <= 1'b0;
            pcov_f_r <= 1'b0;
            gf_r <= 1'b0;
            en_r <= 1'b0;
            thr_r <= '0;
            evt_f_r <= 1'b0;
            rst_en_r <= 1'b0;
            bor_f_r <= 1'b0;
            // Config is caught by a clocked load after release
            load_r <= 1'b1;
            chip_rst_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (CE) begin
            soft_f_r <= soft_f_nxt;
            pin_f_r <= pin_f_nxt;
            pcov_f_r <= pcov_f_nxt;
            gf_r <= gf_nxt;
            en_r <= en_nxt;
            thr_r <= thr_nxt;
            evt_f_r <= evt_f_nxt;
            rst_en_r <= rst_en_nxt;
            bor_f_r <= bor_f_nxt;
            load_r <= load_nxt;
            chip_rst_r <= chip_rst_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            bod_st_r <= rcb_pkg::BOD_OFF;
            ticks_r <= '0;
            osc_d_r <= 1'b0;
            // Same level as the synchroniser reset, so no false fall after reset
            pin_d_r <= 1'b0;
            below_d_r <= 1'b0;
        end else if (CE) begin
            bod_st_r <= bod_st_nxt;
            ticks_r <= ticks_nxt;
            osc_d_r <= osc_s;
            pin_d_r <= pin_s;
            below_d_r <= below_s;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= `RCB_ZERO32;
            ready_r <= 1'b0;
            err_r <= 1'b0;
        end else if (CE) begin
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r <= err_nxt;
        end
    end

    assign PRDATA = rdata_r;
    assign PREADY = ready_r;
    assign PSLVERR = err_r;
    assign CHIP_RESET = chip_rst_r;
    assign BROWNOUT_IRQ = irq_r;
    assign BROWNOUT_DET_ON = en_r;
    assign BROWNOUT_THRESHOLD_SEL = thr_r;
endmodule : rcb_top

// >>> rcb_top_properties.sv
// Port-level checks for the reset-cause and brown-out block
`timescale 1ns/10ps
`include "rcb_consts.svh"
module rcb_chk (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`RCB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic RESET_PIN_DISABLE_CFG,
    input wire logic [7:0] CONFIG_BYTE_TWO,
    input wire logic DEBUG_MODE,
    input wire logic DEBUG_ENABLE_CFG,
    input wire logic SOFT_RESET_REQ,
    input wire logic PC_OVERFLOW,
    input wire logic BROWNOUT_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic CHIP_RESET,
    input wire logic BROWNOUT_IRQ,
    input wire logic BROWNOUT_DET_ON,
    input wire logic [1:0] BROWNOUT_THRESHOLD_SEL
);
    localparam logic [9:0] AP = {`RCB_IDX_PORT2, `RCB_WORD_LSB};
    localparam logic [9:0] AA = {`RCB_IDX_AUX, `RCB_WORD_LSB};
    logic boot_r;
    logic boot_nxt;
    logic rd_ans;
    assign rd_ans = PREADY && !PWRITE;
    always_comb boot_nxt = 1'b1;
    // Low only at the first edge after reset release
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            boot_r <= 1'b0;
        end else begin
            boot_r <= boot_nxt;
        end
    end
    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence acc_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence ans_s;
        PREADY ##1 !PREADY;
    endsequence
    ready_wait_a: assert property (acc_s |=> ans_s) else $error("ready not one pulse");
    top_zero_a: assert property (PRDATA[31:8] == 24'h0) else $error("upper read bits set");
    port_zero_a: assert property (rd_ans && PADDR == AP |-> PRDATA[7:1] == 7'h0)
        else $error("port upper bits set");
    pin_hidden_a: assert property (rd_ans && PADDR == AP && RESET_PIN_DISABLE_CFG
        |-> !PRDATA[0]) else $error("pin bit visible");
    aux_rsv_a: assert property (rd_ans && PADDR == AA |-> PRDATA[2:0] == 3'h0)
        else $error("aux low bits set");
    soft_reset_a: assert property (SOFT_RESET_REQ |=> CHIP_RESET)
        else $error("no soft reset");
    pc_reset_a: assert property (PC_OVERFLOW && !(DEBUG_MODE && !DEBUG_ENABLE_CFG)
        |=> CHIP_RESET) else $error("no overflow reset");
    dbg_hold_a: assert property (PC_OVERFLOW && DEBUG_MODE && !DEBUG_ENABLE_CFG
        && !SOFT_RESET_REQ && !RESET_PIN_DISABLE_CFG |=> !CHIP_RESET) else $error("debug reset");
    irq_gate_a: assert property (BROWNOUT_IRQ
        |-> $past(BROWNOUT_IRQ_ENABLE) && $past(GLOBAL_IRQ_ENABLE)) else $error("irq not gated");
    boot_load_a: assert property (!boot_r |=> ##[0:1] (BROWNOUT_DET_ON == CONFIG_BYTE_TWO[7]
        && BROWNOUT_THRESHOLD_SEL == CONFIG_BYTE_TWO[5:4])) else $error("config not loaded");
endmodule : rcb_chk
bind rcb_top rcb_chk chk (.*);

// >>> rcb_top_test.sv
// Self-checking bench for the reset-cause and brown-out block
`timescale 1ns/10ps
`include "rcb_consts.svh"
module rcb_top_test;
    localparam logic [9:0] AP = {`RCB_IDX_PORT2, `RCB_WORD_LSB};
    localparam logic [9:0] AA = {`RCB_IDX_AUX, `RCB_WORD_LSB};
    localparam logic [9:0] AB = {`RCB_IDX_BOD, `RCB_WORD_LSB};
    logic CLOCK, RST_B, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [`RCB_ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd_v;
    logic RESET_PIN_N, RESET_PIN_DISABLE_CFG, DEBUG_MODE, DEBUG_ENABLE_CFG;
    logic SOFT_RESET_REQ, PC_OVERFLOW, SUPPLY_BELOW, BROWNOUT_IRQ_ENABLE, GLOBAL_IRQ_ENABLE;
    logic CHIP_RESET, BROWNOUT_IRQ, BROWNOUT_DET_ON, er;
    logic [1:0] BROWNOUT_THRESHOLD_SEL, t;
    logic [7:0] CONFIG_BYTE_TWO, g;
    logic [3:0] tk = 4'h0;
    wire LOW_SPEED_OSC = tk[3];
    int fail_count = 0;
    int cmp_count = 0;
    int rst_cnt = 0;
    rcb_top dut (.*);
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    // Slow oscillator runs free at a sixteenth of the core clock
    always @(posedge CLOCK) tk <= tk + 4'h1;
    always @(posedge CLOCK) if (CHIP_RESET === 1'b1) rst_cnt <= rst_cnt + 1;
    function automatic logic [31:0] bodv(logic en, logic [1:0] th, logic ev, rs, bf, lv);
        return {24'h0, en, 1'b0, th, ev, rs, bf, lv};
    endfunction : bodv
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        rd_v = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic fire(input int k, input logic [31:0] e, input int nr);
        int c0;
        RESET_PIN_DISABLE_CFG <= (k == 3);
        DEBUG_MODE <= (k == 1 || k == 2);
        DEBUG_ENABLE_CFG <= (k == 2);
        apb(1'b1, AA, 32'h0);
        c0 = rst_cnt;
        @(posedge CLOCK);
        SOFT_RESET_REQ <= (k == 0);
        PC_OVERFLOW <= (k == 1 || k == 2);
        RESET_PIN_N <= (k != 3);
        @(posedge CLOCK);
        SOFT_RESET_REQ <= 1'b0;
        PC_OVERFLOW <= 1'b0;
        repeat (8) @(posedge CLOCK);
        RESET_PIN_N <= 1'b1;
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AA, 32'h0);
        chk(rd_v, e);
        chk(32'(rst_cnt - c0), 32'(nr));
    endtask : fire
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {RESET_PIN_DISABLE_CFG, DEBUG_MODE, DEBUG_ENABLE_CFG, SOFT_RESET_REQ} = '0;
        {PC_OVERFLOW, SUPPLY_BELOW, BROWNOUT_IRQ_ENABLE, GLOBAL_IRQ_ENABLE} = '0;
        CE = 1'b1;
        RESET_PIN_N = 1'b1;
        g = 8'($urandom(4));
        CONFIG_BYTE_TWO = 8'($urandom);
        repeat (6) @(posedge CLOCK);
        RST_B <= 1'b1;
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(CONFIG_BYTE_TWO[7], CONFIG_BYTE_TWO[5:4], 0, CONFIG_BYTE_TWO[2], 0, 0));
        apb(1'b1, AB, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, AB, 32'(i) << 4);
            repeat (2) @(posedge CLOCK);
            chk(32'(BROWNOUT_THRESHOLD_SEL), 32'(i));
        end
        RESET_PIN_N <= 1'b0;
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AP, 32'h0);
        chk(rd_v, 32'h0);
        RESET_PIN_N <= 1'b1;
        repeat (8) @(posedge CLOCK);
        apb(1'b1, AP, 32'hFF);
        apb(1'b0, AP, 32'h0);
        chk(rd_v, 32'h1);
        apb(1'b1, AA, {28'h0, g[3], 3'b110});
        apb(1'b0, AA, 32'h0);
        chk(rd_v, {28'h0, g[3], 3'b000});
        fire(0, 32'h80, 1);
        fire(1, 32'h20, 0);
        fire(2, 32'h20, 1);
        fire(3, 32'h40, 1);
        apb(1'b0, AP, 32'h0);
        chk(rd_v, 32'h0);
        RESET_PIN_DISABLE_CFG <= 1'b0;
        apb(1'b1, AB, 32'h0);
        SUPPLY_BELOW <= 1'b1;
        BROWNOUT_IRQ_ENABLE <= 1'b1;
        GLOBAL_IRQ_ENABLE <= 1'b1;
        t = 2'($urandom);
        apb(1'b1, AB, bodv(0, t, 0, 0, 0, 1));
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(0, t, 0, 0, 0, 0));
        apb(1'b1, AB, bodv(1, t, 0, 0, 0, 0));
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(1, t, 0, 0, 0, 0));
        chk(32'(BROWNOUT_DET_ON), 32'h1);
        repeat (100) @(posedge CLOCK);
        apb(1'b1, AB, bodv(1, t, 0, 0, 0, 0));
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(1, t, 0, 0, 0, 1));
        SUPPLY_BELOW <= 1'b0;
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(1, t, 1, 0, 0, 0));
        chk(32'(BROWNOUT_IRQ), 32'h1);
        GLOBAL_IRQ_ENABLE <= 1'b0;
        repeat (2) @(posedge CLOCK);
        chk(32'(BROWNOUT_IRQ), 32'h0);
        apb(1'b1, AB, bodv(1, t, 0, 0, 0, 0));
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(1, t, 0, 0, 0, 0));
        SUPPLY_BELOW <= 1'b1;
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AB, 32'h0);
        chk(rd_v, bodv(1, t, 1, 0, 0, 1));
        apb(1'b1, AB, bodv(1, t, 0, 1, 0, 0));
        SUPPLY_BELOW <= 1'b0;
        repeat (8) @(posedge CLOCK);
        SUPPLY_BELOW <= 1'b1;
        repeat (8) @(posedge CLOCK);
        apb(1'b0, AB, 32'h0);
        // Detector stays valid after the reload when config keeps it enabled
        chk(rd_v, bodv(CONFIG_BYTE_TWO[7], CONFIG_BYTE_TWO[5:4], 1, CONFIG_BYTE_TWO[2], 1, CONFIG_BYTE_TWO[7]));
        chk(32'(rst_cnt), 32'h4);
        apb(1'b0, 10'h284, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b0, AB | 10'h1, 32'h0);
        chk(32'(er), 32'h1);
        summarize();
    end
endmodule : rcb_top_test
